//--- ircr_pkg.sv
// Constants, types and helpers of the infrared transceiver control registers
//
// Contract
// - Control bit 0 picks power: 0 shutdown, 1 normal; resets to shutdown.
// - Control bit 1 enables receive line drive; 0 leaves it floating except while a read reply is shifted out; default off.
// - Control bit 2 enables the emitter driver; default off.
// - Bit 4 with bit 1 gives one-clock low pulse after individual writes only.
// - While bit 4 is set the photodiode is cut from the receive line.
// - Mode register codes decoded and checked against supported-mode capability.
// - Unsupported mode write loads 00h and gives no acknowledge pulse.
// - Power register bits 7:4 set emitter current; bits 3:0 ignored.
// - Power register resets to upper nibble 7, the 256 mA level.
// - Data word is one start bit then one byte, sampled on serial clock.
// - Device answers individual address 010 and broadcast address 111.
package ircr_pkg;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL    = 4'h0;
  localparam logic [3:0] IDX_MODE    = 4'h1;
  localparam logic [3:0] IDX_POWER   = 4'h2;
  localparam logic [2:0] ADDR_INDIV  = 3'h2;
  localparam logic [2:0] ADDR_BCAST  = 3'h7;
  localparam int         BIT_POWER   = 0;
  localparam int         BIT_RXOE    = 1;
  localparam int         BIT_EMIT    = 2;
  localparam int         BIT_ACK     = 4;
  localparam logic [7:0] CTRL_MASK   = 8'h17;
  localparam logic [7:0] POWER_MASK  = 8'hf0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [7:0] POWER_RESET = 8'h70;

  // ---------------------------------------------------------------
  // Mode codes
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_SIR    = 8'h00;
  localparam logic [7:0] MODE_MIR    = 8'h01;
  localparam logic [7:0] MODE_FIR    = 8'h02;
  localparam logic [7:0] MODE_FIRALT = 8'h03;
  localparam logic [7:0] MODE_VFIR   = 8'h05;
  localparam logic [7:0] MODE_SIRALT = 8'h08;
  localparam logic [7:0] MODE_CIR    = 8'h20;

  // ---------------------------------------------------------------
  // Frame layout and timing
  // ---------------------------------------------------------------
  localparam logic [4:0] HDR_LAST    = 5'h07;
  localparam logic [4:0] WR_LAST     = 5'h10;
  localparam logic [4:0] TURN_LAST   = 5'h03;
  localparam logic [4:0] RD_LAST     = 5'h07;
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         IDLE_TIMEOUT_NS = 2000;
  localparam logic [7:0] IDLE_TIMEOUT_CYC = 8'(IDLE_TIMEOUT_NS / CLK_PERIOD_NS);
  localparam logic [9:0] CUR_MA_MAX  = 10'h200;
  localparam logic [9:0] CUR_MA_RESET = 10'h100;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR, ST_WDATA, ST_ACK, ST_RTURN, ST_RDATA, ST_SKIP
  } ircr_state_t;

  typedef struct packed {
    logic ackPulseEnable;
    logic emitterDriveEnable;
    logic receiveOutputEnable;
    logic powerStateSelect;
  } ircr_ctrl_t;

  typedef struct packed {
    ircr_ctrl_t ctrl;
    logic [7:0] mode;
    logic [9:0] emitterCurrentMa;
  } ircr_status_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [9:0] ircr_current_ma(input logic [3:0] n);
    logic [9:0] r;
    r = 10'h000;
    if (n[3]) begin
      r = CUR_MA_MAX;
    end else begin
      unique case (n[2:0])
        3'h7: r = 10'h100;
        3'h6: r = 10'h080;
        3'h5: r = 10'h040;
        3'h4: r = 10'h030;
        3'h3: r = 10'h020;
        3'h2: r = 10'h010;
        3'h1: r = 10'h008;
        3'h0: r = 10'h000;
      endcase
    end
    return r;
  endfunction

  // Support mask bit per mode code
  function automatic logic ircr_mode_ok(input logic [7:0] m, input logic [15:0] sup);
    logic ok;
    ok = 1'b0;
    case (m)
      MODE_SIR:    ok = sup[0];
      MODE_MIR:    ok = sup[1];
      MODE_FIR:    ok = sup[2];
      MODE_FIRALT: ok = sup[3];
      MODE_CIR:    ok = sup[4];
      MODE_VFIR:   ok = sup[5];
      MODE_SIRALT: ok = sup[8];
      default:     ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

//--- ircr_sync_edge.sv
// Two-flop synchroniser with rising edge detect
`timescale 1ns/1ps
module ircr_sync_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Asynchronous input
  input  wire logic asyncIn,
  // Synchronised level and edge
  output logic      level,
  output logic      rise
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_stage1;
  logic next_stage2;
  logic next_stage3;

  always_comb begin
    next_stage1 = asyncIn;
    next_stage2 = stage1;
    next_stage3 = stage2;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;

endmodule // ircr_sync_edge

//--- ircr_regs.sv
// Control register bank with serial control bus slave
`timescale 1ns/1ps
module ircr_regs
  import ircr_pkg::*;
#(
  parameter logic [7:0] SUPPORT_LO = 8'hff,
  parameter logic [7:0] SUPPORT_HI = 8'h01
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset,
  // Serial control bus
  input  wire logic   sclkPin,
  input  wire logic   txdPin,
  // Receive data line
  output logic        rxdOut,
  output logic        rxdOe,
  // Photodiode receiver
  input  wire logic   photoRxPin,
  // Configuration to analog front end
  output ircr_status_t status
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic sclkRise;
  logic txdBit;
  logic photoBit;

  ircr_sync_edge uSclk (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (sclkPin),
    .level   (),
    .rise    (sclkRise)
  );

  ircr_sync_edge uTxd (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (txdPin),
    .level   (txdBit),
    .rise    ()
  );

  ircr_sync_edge uPhoto (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (photoRxPin),
    .level   (photoBit),
    .rise    ()
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ircr_state_t state;
  ircr_state_t next_state;
  logic [4:0]  bitCnt;
  logic [4:0]  next_bitCnt;
  logic [15:0] frame;
  logic [15:0] next_frame;
  logic [7:0]  respShift;
  logic [7:0]  next_respShift;
  logic [7:0]  idleCnt;
  logic [7:0]  next_idleCnt;
  logic [7:0]  ctrlReg;
  logic [7:0]  next_ctrlReg;
  logic [7:0]  modeReg;
  logic [7:0]  next_modeReg;
  logic [7:0]  powerReg;
  logic [7:0]  next_powerReg;
  logic [9:0]  currentMa;
  logic [9:0]  next_currentMa;
  logic        next_rxdOut;
  logic        next_rxdOe;

  // Frame fields, bits arrive LSB first
  logic [3:0]  frameIndex;
  logic [2:0]  frameAddr;
  logic        addrIndiv;
  logic        addrHit;
  logic [7:0]  wrData;
  logic        commit;
  logic        modeOk;
  logic        ackGo;
  logic [7:0]  readValue;

  assign frameIndex = frame[4:1];
  assign frameAddr  = frame[7:5];
  assign addrIndiv  = (frameAddr == ADDR_INDIV);
  assign addrHit    = addrIndiv || (frameAddr == ADDR_BCAST);
  assign wrData     = {txdBit, frame[15:9]};
  assign commit     = (state == ST_WDATA) && sclkRise && (bitCnt == WR_LAST);
  assign modeOk     = ircr_mode_ok(wrData, {SUPPORT_HI, SUPPORT_LO});

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  always_comb begin
    unique case (frameIndex)
      IDX_CTRL:  readValue = ctrlReg & CTRL_MASK;
      IDX_MODE:  readValue = modeReg;
      IDX_POWER: readValue = powerReg & POWER_MASK;
      default:   readValue = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Frame engine and registers
  // ---------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_bitCnt    = bitCnt;
    next_frame     = frame;
    next_respShift = respShift;
    next_ctrlReg   = ctrlReg;
    next_modeReg   = modeReg;
    next_powerReg  = powerReg;
    next_currentMa = currentMa;
    ackGo          = 1'b0;
    next_idleCnt   = sclkRise ? 8'h00 : idleCnt + 8'h01;
    unique case (state)
      ST_IDLE: begin
        // First clock edge opens a frame with the direction bit
        if (sclkRise) begin
          next_frame  = {15'h0000, txdBit};
          next_bitCnt = 5'h01;
          next_state  = ST_HDR;
        end
      end
      ST_HDR: begin
        if (sclkRise) begin
          next_frame[bitCnt[3:0]] = txdBit;
          next_bitCnt = bitCnt + 5'h01;
          if (bitCnt == HDR_LAST) begin
            // Fields are whole only after this bit lands
            if (!({txdBit, frame[6:5]} inside {ADDR_INDIV, ADDR_BCAST})) begin
              next_state = ST_SKIP;
            end else if (frame[0]) begin
              next_state = ST_WDATA;
            end else if ((frame[4:1] <= IDX_POWER) && ({txdBit, frame[6:5]} == ADDR_INDIV)) begin
              next_state  = ST_RTURN;
              next_bitCnt = 5'h00;
            end else begin
              next_state = ST_SKIP;
            end
          end
        end
      end
      ST_WDATA: begin
        if (sclkRise) begin
          next_frame[bitCnt[3:0]] = txdBit;
          next_bitCnt = bitCnt + 5'h01;
          if (bitCnt == WR_LAST) begin
            next_state = ST_IDLE;
            // Start bit must be high, and broadcasts never pulse
            if (frame[8]) begin
              unique case (frameIndex)
                IDX_CTRL: begin
                  next_ctrlReg = wrData & CTRL_MASK;
                  ackGo = 1'b1;
                end
                IDX_MODE: begin
                  next_modeReg = modeOk ? wrData : MODE_SIR;
                  ackGo = modeOk;
                end
                IDX_POWER: begin
                  next_powerReg  = wrData & POWER_MASK;
                  next_currentMa = ircr_current_ma(wrData[7:4]);
                  ackGo = 1'b1;
                end
                default: ackGo = 1'b0;
              endcase
            end
            if (ackGo && addrIndiv && next_ctrlReg[BIT_ACK] && next_ctrlReg[BIT_RXOE]) begin
              next_state = ST_ACK;
            end
          end
        end
      end
      ST_ACK: begin
        // Low pulse ends on the next serial clock edge
        if (sclkRise) begin
          next_state = ST_IDLE;
        end
      end
      ST_RTURN: begin
        if (sclkRise) begin
          next_bitCnt = bitCnt + 5'h01;
          if (bitCnt == TURN_LAST) begin
            next_respShift = readValue;
            next_bitCnt    = 5'h00;
            next_state     = ST_RDATA;
          end
        end
      end
      ST_RDATA: begin
        if (sclkRise) begin
          next_respShift = {1'b0, respShift[7:1]};
          next_bitCnt    = bitCnt + 5'h01;
          if (bitCnt == RD_LAST) begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_SKIP: next_state = ST_SKIP;
      default: next_state = ST_IDLE;
    endcase
    // Serial clock may stop mid-frame; drop the frame after a quiet gap
    if ((state != ST_IDLE) && (idleCnt >= IDLE_TIMEOUT_CYC)) begin
      next_state = ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // Receive line drive
  // ---------------------------------------------------------------
  always_comb begin
    if (next_state == ST_RDATA) begin
      next_rxdOe  = 1'b1;
      next_rxdOut = next_respShift[0];
    end else if (next_ctrlReg[BIT_ACK]) begin
      // Photodiode cut off, line idles high between pulses
      next_rxdOe  = next_ctrlReg[BIT_RXOE];
      next_rxdOut = (next_state != ST_ACK);
    end else begin
      next_rxdOe  = next_ctrlReg[BIT_RXOE];
      next_rxdOut = photoBit;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= ST_IDLE;
      bitCnt    <= 5'h00;
      frame     <= 16'h0000;
      respShift <= 8'h00;
      idleCnt   <= 8'h00;
      ctrlReg   <= CTRL_RESET;
      modeReg   <= MODE_RESET;
      powerReg  <= POWER_RESET;
      currentMa <= CUR_MA_RESET;
      rxdOut    <= 1'b1;
      rxdOe     <= 1'b0;
    end else begin
      state     <= next_state;
      bitCnt    <= next_bitCnt;
      frame     <= next_frame;
      respShift <= next_respShift;
      idleCnt   <= next_idleCnt;
      ctrlReg   <= next_ctrlReg;
      modeReg   <= next_modeReg;
      powerReg  <= next_powerReg;
      currentMa <= next_currentMa;
      rxdOut    <= next_rxdOut;
      rxdOe     <= next_rxdOe;
    end
  end

  assign status = {ctrlReg[BIT_ACK], ctrlReg[BIT_EMIT], ctrlReg[BIT_RXOE], ctrlReg[BIT_POWER],
                   modeReg, currentMa};

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_ctrl_wr;
    commit && frame[8] && (frameIndex == IDX_CTRL);
  endsequence

  sequence s_ack_wr;
    s_ctrl_wr ##0 addrIndiv && wrData[BIT_ACK] && wrData[BIT_RXOE];
  endsequence

  property p_power_sel;
    s_ctrl_wr |=> (status.ctrl.powerStateSelect == $past(wrData[BIT_POWER]));
  endproperty
  a_power_sel: assert property (p_power_sel) else $error("power bit not loaded");

  property p_rx_gate;
    (!status.ctrl.receiveOutputEnable && state != ST_RDATA)[*2] |-> !rxdOe;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("receive line driven while off");

  property p_emit;
    s_ctrl_wr |=> (status.ctrl.emitterDriveEnable == $past(wrData[BIT_EMIT]));
  endproperty
  a_emit: assert property (p_emit) else $error("emitter bit not loaded");

  property p_ack_pulse;
    s_ack_wr ##1 !sclkRise |=> rxdOe && !rxdOut;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("no acknowledge pulse");

  property p_no_bcast_ack;
    commit && !addrIndiv |=> state != ST_ACK;
  endproperty
  a_no_bcast_ack: assert property (p_no_bcast_ack) else $error("broadcast acknowledged");

  property p_photo_cut;
    (status.ctrl.ackPulseEnable && state == ST_IDLE)[*2] |-> rxdOut;
  endproperty
  a_photo_cut: assert property (p_photo_cut) else $error("photodiode reached line");

  property p_mode_bad;
    commit && frame[8] && frameIndex == IDX_MODE && !modeOk
      |=> status.mode == MODE_SIR && state != ST_ACK;
  endproperty
  a_mode_bad: assert property (p_mode_bad) else $error("bad mode not replaced");

  property p_current_max;
    commit && frame[8] && frameIndex == IDX_POWER && wrData[7]
      |=> status.emitterCurrentMa == CUR_MA_MAX;
  endproperty
  a_current_max: assert property (p_current_max) else $error("current not at maximum");

  property p_power_reset;
    $fell(reset) |-> powerReg == POWER_RESET && status.emitterCurrentMa == CUR_MA_RESET;
  endproperty
  a_power_reset: assert property (p_power_reset) else $error("power reset value wrong");

  property p_unused_zero;
    ctrlReg[3] == 1'b0 && powerReg[3:0] == 4'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

  property p_addr_only;
    state == ST_WDATA |-> addrHit;
  endproperty
  a_addr_only: assert property (p_addr_only) else $error("foreign address accepted");

endmodule // ircr_regs

//--- ircr_ctl_model.sv
// Controller model driving the serial control bus of the transceiver registers
`timescale 1ns/1ps
module ircr_ctl_model
  import ircr_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Serial control bus
  output logic      sclkPin,
  output logic      txdPin,
  // Receive line from the device
  input  wire logic rxdOut,
  input  wire logic rxdOe
);
  initial begin
    sclkPin = 1'b0;
    txdPin  = 1'b0;
  end

  // ---------------------------------------------------------------
  // Bit and frame primitives
  // ---------------------------------------------------------------
  // 100 ns low then 100 ns high; line sampled just before the rise
  task automatic bit_edge(input logic b, output logic rv, output logic ro);
    @(posedge clk);
    sclkPin <= 1'b0;
    txdPin  <= b;
    repeat (3) @(posedge clk);
    @(negedge clk);
    // Released line sits at its pull-up level
    rv = rxdOe ? rxdOut : 1'b1;
    ro = rxdOe;
    @(posedge clk);
    sclkPin <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Clock stands still low; gap outlasts the idle timeout
  task automatic gap();
    @(posedge clk);
    sclkPin <= 1'b0;
    txdPin  <= 1'b0;
    repeat (100) @(posedge clk);
  endtask

  task automatic header(input logic dir, input logic [3:0] idx, input logic [2:0] addr);
    logic       rv;
    logic       ro;
    logic [7:0] h;
    h = {addr, idx, dir};
    for (int i = 0; i < 8; i++) begin
      bit_edge(h[i], rv, ro);
    end
  endtask

  // ---------------------------------------------------------------
  // Transactions
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] idx, input logic [2:0] addr, input logic start,
                    input logic [7:0] data, output logic ack);
    logic rv;
    logic ro;
    header(1'b1, idx, addr);
    bit_edge(start, rv, ro);
    for (int i = 0; i < 8; i++) begin
      bit_edge(data[i], rv, ro);
    end
    // Ack stands until the next rise, so look well inside it
    repeat (3) @(posedge clk);
    @(negedge clk);
    ack = rxdOe & ~rxdOut;
    // One more clock rise must end the pulse
    bit_edge(1'b0, rv, ro);
    @(negedge clk);
    ack = ack & rxdOut;
    gap();
  endtask

  task automatic rd(input logic [3:0] idx, output logic [7:0] data, output logic drv);
    logic       rv;
    logic       ro;
    logic [3:0] turn;
    turn = 4'he;
    drv  = 1'b1;
    header(1'b0, idx, ADDR_INDIV);
    for (int i = 0; i < 4; i++) begin
      bit_edge(turn[i], rv, ro);
    end
    for (int i = 0; i < 8; i++) begin
      bit_edge(1'b1, rv, ro);
      data[i] = rv;
      drv     = drv & ro;
    end
    gap();
  endtask
endmodule // ircr_ctl_model

//--- tb_ir_transceiver_control_registers.sv
// Self-checking testbench of the transceiver control registers
`timescale 1ns/1ps
module tb_ir_transceiver_control_registers
  import ircr_pkg::*;
();
  logic         clk;
  logic         reset;
  logic         photoRxPin;
  logic         sclkPin;
  logic         txdPin;
  logic         rxdOut;
  logic         rxdOe;
  ircr_status_t status;
  int           nFail;
  int           comparisons;
  logic         ack;
  logic         drv;
  logic [7:0]   rdData;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // CIR left out of the support mask so a listed code gets refused
  ircr_regs #(.SUPPORT_LO(8'hef), .SUPPORT_HI(8'h01)) dut (
    .clk(clk), .reset(reset), .sclkPin(sclkPin), .txdPin(txdPin), .rxdOut(rxdOut),
    .rxdOe(rxdOe), .photoRxPin(photoRxPin), .status(status));

  ircr_ctl_model ctl (
    .clk(clk), .sclkPin(sclkPin), .txdPin(txdPin), .rxdOut(rxdOut), .rxdOe(rxdOe));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    chk(10'(status.ctrl), 10'h000, "ctrl after reset");
    chk(10'(rxdOe), 10'h000, "line floats after reset");
    chk(10'(status.mode), 10'h000, "mode after reset");
    chk(status.emitterCurrentMa, 10'h100, "current after reset");
    ctl.rd(IDX_POWER, rdData, drv);
    chk(10'(rdData), 10'h070, "power readback");
    chk(10'(drv), 10'h001, "read drives line");
    ctl.rd(IDX_CTRL, rdData, drv);
    chk(10'(rdData), 10'h000, "ctrl readback");
    $display("test reset done");
  endtask

  task automatic test_ctrl();
    ctl.wr(IDX_CTRL, ADDR_INDIV, 1'b1, 8'hff, ack);
    chk(10'(status.ctrl), 10'h00f, "ctrl all set");
    chk(10'(ack), 10'h001, "ack pulse");
    ctl.rd(IDX_CTRL, rdData, drv);
    chk(10'(rdData), 10'h017, "unused bits read zero");
    ctl.wr(IDX_CTRL, ADDR_INDIV, 1'b1, 8'h01, ack);
    chk(10'(status.ctrl), 10'h001, "normal power only");
    chk(10'(ack), 10'h000, "no ack when disabled");
    chk(10'(rxdOe), 10'h000, "line floats");
    ctl.wr(IDX_CTRL, ADDR_INDIV, 1'b1, 8'h13, ack);
    chk(10'(ack), 10'h001, "ack after enable");
    $display("test ctrl done");
  endtask

  task automatic test_photo();
    photoRxPin <= 1'b0;
    repeat (10) @(posedge clk);
    chk(10'({rxdOe, rxdOut}), 10'h003, "photodiode cut off");
    photoRxPin <= 1'b1;
    ctl.wr(IDX_CTRL, ADDR_INDIV, 1'b1, 8'h03, ack);
    chk(10'(ack), 10'h000, "no ack after disable");
    photoRxPin <= 1'b0;
    repeat (10) @(posedge clk);
    chk(10'({rxdOe, rxdOut}), 10'h002, "photodiode low passes");
    photoRxPin <= 1'b1;
    repeat (10) @(posedge clk);
    chk(10'({rxdOe, rxdOut}), 10'h003, "photodiode high passes");
    ctl.wr(IDX_CTRL, ADDR_INDIV, 1'b1, 8'h13, ack);
    $display("test photo done");
  endtask

  task automatic test_modes();
    logic [7:0] code [8];
    logic [7:0] want [8];
    logic [7:0] ackWant;
    code    = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h20, 8'h08, 8'h04, 8'h00};
    want    = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h00, 8'h08, 8'h00, 8'h00};
    ackWant = 8'haf;
    for (int i = 0; i < 8; i++) begin
      ctl.wr(IDX_MODE, ADDR_INDIV, 1'b1, code[i], ack);
      chk(10'(status.mode), 10'(want[i]), "mode stored");
      chk(10'(ack), 10'(ackWant[i]), "mode ack");
      ctl.rd(IDX_MODE, rdData, drv);
      chk(10'(rdData), 10'(want[i]), "mode readback");
    end
    $display("test modes done");
  endtask

  task automatic test_power();
    logic [9:0] maTbl [8];
    logic [3:0] n;
    maTbl = '{10'h000, 10'h008, 10'h010, 10'h020, 10'h030, 10'h040, 10'h080, 10'h100};
    for (int i = 0; i < 16; i++) begin
      n = 4'(i);
      ctl.wr(IDX_POWER, ADDR_INDIV, 1'b1, {n, 4'ha}, ack);
      chk(status.emitterCurrentMa, n[3] ? 10'h200 : maTbl[n[2:0]], "current");
      chk(10'(ack), 10'h001, "power ack");
    end
    ctl.rd(IDX_POWER, rdData, drv);
    chk(10'(rdData), 10'h0f0, "low nibble dropped");
    $display("test power done");
  endtask

  task automatic test_addr();
    ctl.wr(IDX_POWER, ADDR_BCAST, 1'b1, 8'h30, ack);
    chk(status.emitterCurrentMa, 10'h020, "broadcast stored");
    chk(10'(ack), 10'h000, "broadcast no ack");
    ctl.wr(IDX_POWER, 3'h3, 1'b1, 8'h50, ack);
    chk(status.emitterCurrentMa, 10'h020, "foreign address ignored");
    ctl.wr(IDX_POWER, ADDR_INDIV, 1'b0, 8'h50, ack);
    chk(status.emitterCurrentMa, 10'h020, "missing start bit");
    chk(10'(ack), 10'h000, "no ack without start");
    ctl.wr(4'h3, ADDR_INDIV, 1'b1, 8'hff, ack);
    chk(10'(status.ctrl), 10'h00b, "unused index keeps ctrl");
    chk(10'(status.mode), 10'h000, "unused index keeps mode");
    chk(10'(ack), 10'h000, "unused index no ack");
    $display("test addr done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    reset      = 1'b1;
    photoRxPin = 1'b1;
    nFail      = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    test_reset();
    test_ctrl();
    test_photo();
    test_modes();
    test_power();
    test_addr();
    tally_and_finish();
  end

  initial begin
    repeat (99000) @(posedge clk);
    nFail++;
    $display("BAD %0t run limit reached", $time);
    tally_and_finish();
  end
endmodule // tb_ir_transceiver_control_registers
